/* crm_pkg.sv */
// package: constants and types for the code area ram remap block
package crm_pkg;

  // ----------------------------------------------------------------
  // address spaces
  // ----------------------------------------------------------------
  localparam int SPACE_KB = 64;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_IDX = 12'hfde;
  localparam logic [11:0] COMMIT_IDX = 12'hfdf;
  localparam logic [15:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [15:0] COMMIT_ADDR = {2'h0, COMMIT_IDX, 2'h0};

  // ----------------------------------------------------------------
  // fields and codes
  // ----------------------------------------------------------------
  localparam int BIT_RST = 0;
  localparam int BIT_RAM = 1;
  localparam int BIT_VEC = 2;
  localparam logic [7:0] UNLOCK_CODE = 8'hd4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h083f;
  localparam logic [15:0] ROM_LO = 16'hc000;
  localparam logic [15:0] VCALL_LO = 16'hffa0;
  localparam logic [15:0] VCALL_HI = 16'hffbf;
  localparam logic [15:0] VINT_LO = 16'hffcc;
  localparam logic [15:0] VINT_HI = 16'hfffd;
  localparam logic [15:0] RELOC_MASK = 16'h01ff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_RAM = 2'b01,
    TGT_ROM = 2'b10,
    TGT_SWI = 2'b11
  } crm_tgt_e;

  typedef struct packed {
    logic vec;
    logic ram;
  } crm_map_s;

  typedef struct packed {
    logic ram_sel;
    logic rom_sel;
    logic [15:0] addr;
  } crm_mem_s;

endpackage : crm_pkg

/* crm_space_dec.sv */
// module: address decoder for one 64 kbyte space
module crm_space_dec #(
  parameter bit CODE_SPACE = 1'b1
) (
  input wire logic [15:0] addr,
  input wire logic vec_fetch,
  input crm_pkg::crm_map_s map,
  output crm_pkg::crm_tgt_e tgt,
  output logic [15:0] eff_addr
);

  // ----------------------------------------------------------------
  // vector relocation, code space only; reset vector is outside range
  // ----------------------------------------------------------------
  wire in_vcall = addr >= crm_pkg::VCALL_LO && addr <= crm_pkg::VCALL_HI;
  wire in_vint = addr >= crm_pkg::VINT_LO && addr <= crm_pkg::VINT_HI;
  wire reloc = CODE_SPACE && vec_fetch && map.vec && (in_vcall || in_vint); // [R8] [R9] [R10]

  assign eff_addr = reloc ? (addr & crm_pkg::RELOC_MASK) : addr; // [R10]

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  wire in_ram = eff_addr >= crm_pkg::RAM_LO && eff_addr <= crm_pkg::RAM_HI;
  wire in_rom = eff_addr >= crm_pkg::ROM_LO;
  wire ram_vis = !CODE_SPACE || map.ram; // [R3] [R4] [R5]

  assign tgt = in_rom ? crm_pkg::TGT_ROM : // [R2]
               (in_ram && ram_vis) ? crm_pkg::TGT_RAM : // [R4]
               in_ram ? crm_pkg::TGT_SWI : // [R6]
               crm_pkg::TGT_NONE;

endmodule : crm_space_dec

/* crm_top.sv */
// module: code area ram remap, apb registers and both space decoders
// Operation
// [R1] code and data spaces are separate 64 kbyte spaces with their own decoders
// [R2] code decoder can map both ram and program rom into code space
// [R3] after reset ram appears only in data space
// [R4] committed ram map bit set maps ram at code 0x0040 to 0x083f
// [R5] committed ram map bit clear keeps ram out of that code window
// [R6] fetches from that window without ram return the software interrupt opcode
// [R7] control writes change mapping only after unlock code 0xd4 is committed
// [R8] committed vector remap moves call and interrupt tables to ram, never reset vector
// [R9] remap clear: call table 0xffa0-0xffbf, interrupt table 0xffcc-0xfffd
// [R10] remap set: call table 0x01a0-0x01bf, interrupt table 0x01cc-0x01fd
// [R11] software sets both ram map and vector remap before committing
// [R12] control bits 7 to 3 read as zero and are not writable
// [R13] only the unlock code acts on the commit register, others ignored
// [R14] software writes commit register plainly, never read modify write
// [R15] readback at commit address shows committed ram map bit1, vector bit2
// [R16] pending values kept apart, copied to committed on the unlock write cycle
//
// Decided for this implementation: the APB interface to the registers.
module crm_top #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8,
  parameter logic [7:0] SWI_OPCODE = 8'hff,
  parameter logic [7:0] UNMAPPED_DATA = 8'h00
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cf_valid,
  input wire logic cf_vector,
  input wire logic [15:0] cf_addr,
  output crm_pkg::crm_mem_s cf_mem,
  input wire logic [7:0] cf_ram_rdata,
  input wire logic [7:0] cf_rom_rdata,
  output logic cf_rvalid_q,
  output logic [7:0] cf_rdata_q,
  input wire logic dt_valid,
  input wire logic [15:0] dt_addr,
  output crm_pkg::crm_mem_s dt_mem,
  input wire logic [7:0] dt_ram_rdata,
  input wire logic [7:0] dt_rom_rdata,
  output logic dt_rvalid_q,
  output logic [7:0] dt_rdata_q,
  output crm_pkg::crm_map_s map_committed
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W != crm_pkg::ADDR_W) begin : g_bad_aw
    $error("crm_top: address width must match a 64 kbyte space");
  end
  if (DATA_W != crm_pkg::DATA_W) begin : g_bad_dw
    $error("crm_top: data width must be 8");
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire hit_ctrl = paddr == crm_pkg::CTRL_ADDR;
  wire hit_commit = paddr == crm_pkg::COMMIT_ADDR;
  wire mapped = hit_ctrl || hit_commit;
  wire access = psel && penable;
  wire wr_en = access && pwrite && pstrb[0];
  wire wr_ctrl = wr_en && hit_ctrl;
  wire wr_commit = wr_en && hit_commit;
  wire [7:0] wbyte = pwdata[7:0];
  wire unlock = wr_commit && (wbyte == crm_pkg::UNLOCK_CODE); // [R7] [R13]

  // zero wait state slave
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // pending control register
  // ----------------------------------------------------------------
  logic ram_pend_q;
  logic ram_pend_d;
  logic vec_pend_q;
  logic vec_pend_d;
  logic rst_pend_q;
  logic rst_pend_d;

  // only bits 2 to 0 store; upper bits have no flops
  assign ram_pend_d = wr_ctrl ? wbyte[crm_pkg::BIT_RAM] : ram_pend_q; // [R12]
  assign vec_pend_d = wr_ctrl ? wbyte[crm_pkg::BIT_VEC] : vec_pend_q; // [R12]
  assign rst_pend_d = wr_ctrl ? wbyte[crm_pkg::BIT_RST] : rst_pend_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ram_pend_q <= crm_pkg::CTRL_RESET[crm_pkg::BIT_RAM];
      vec_pend_q <= crm_pkg::CTRL_RESET[crm_pkg::BIT_VEC];
      rst_pend_q <= crm_pkg::CTRL_RESET[crm_pkg::BIT_RST];
    end else begin
      ram_pend_q <= ram_pend_d;
      vec_pend_q <= vec_pend_d;
      rst_pend_q <= rst_pend_d;
    end
  end

  // ----------------------------------------------------------------
  // committed mapping state
  // ----------------------------------------------------------------
  logic ram_map_state_q;
  logic ram_map_state_d;
  logic vector_map_state_q;
  logic vector_map_state_d;

  // the pending value as held before this cycle's write is committed
  assign ram_map_state_d = unlock ? ram_pend_q : ram_map_state_q; // [R16] [R7]
  assign vector_map_state_d = unlock ? vec_pend_q : vector_map_state_q; // [R16] [R8]

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ram_map_state_q <= crm_pkg::STATE_RESET[crm_pkg::BIT_RAM]; // [R3]
      vector_map_state_q <= crm_pkg::STATE_RESET[crm_pkg::BIT_VEC];
    end else begin
      ram_map_state_q <= ram_map_state_d;
      vector_map_state_q <= vector_map_state_d;
    end
  end

  assign map_committed.ram = ram_map_state_q;
  assign map_committed.vec = vector_map_state_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [7:0] ctrl_rd = {5'h00, vec_pend_q, ram_pend_q, rst_pend_q}; // [R12]
  wire [7:0] state_rd = {5'h00, vector_map_state_q, ram_map_state_q, 1'b0}; // [R15]
  wire rd_en = access && !pwrite;

  // commit address reads the readback, never the written code
  assign prdata = !rd_en ? 32'h0000_0000 :
                  hit_ctrl ? {24'h00_0000, ctrl_rd} :
                  hit_commit ? {24'h00_0000, state_rd} : // [R15]
                  32'h0000_0000;

  // ----------------------------------------------------------------
  // code space decode
  // ----------------------------------------------------------------
  crm_pkg::crm_tgt_e cf_tgt;
  logic [15:0] cf_eff;

  crm_space_dec #(
    .CODE_SPACE(1'b1)
  ) u_code_dec (
    .addr(cf_addr),
    .vec_fetch(cf_vector),
    .map(map_committed),
    .tgt(cf_tgt),
    .eff_addr(cf_eff)
  ); // [R1] [R2]

  assign cf_mem.ram_sel = cf_valid && (cf_tgt == crm_pkg::TGT_RAM); // [R4] [R5]
  assign cf_mem.rom_sel = cf_valid && (cf_tgt == crm_pkg::TGT_ROM); // [R2]
  assign cf_mem.addr = cf_eff;

  // ----------------------------------------------------------------
  // data space decode, ram always visible here
  // ----------------------------------------------------------------
  crm_pkg::crm_tgt_e dt_tgt;
  logic [15:0] dt_eff;
  crm_pkg::crm_map_s dt_map;

  assign dt_map.ram = 1'b1;
  assign dt_map.vec = 1'b0;

  crm_space_dec #(
    .CODE_SPACE(1'b0)
  ) u_data_dec (
    .addr(dt_addr),
    .vec_fetch(1'b0),
    .map(dt_map),
    .tgt(dt_tgt),
    .eff_addr(dt_eff)
  ); // [R1] [R3]

  assign dt_mem.ram_sel = dt_valid && (dt_tgt == crm_pkg::TGT_RAM);
  assign dt_mem.rom_sel = dt_valid && (dt_tgt == crm_pkg::TGT_ROM);
  assign dt_mem.addr = dt_eff;

  // ----------------------------------------------------------------
  // fetch data selection
  // ----------------------------------------------------------------
  logic [7:0] cf_sel;
  logic [7:0] dt_sel;

  always_comb begin
    unique case (cf_tgt)
      crm_pkg::TGT_RAM: cf_sel = cf_ram_rdata; // [R4]
      crm_pkg::TGT_ROM: cf_sel = cf_rom_rdata;
      crm_pkg::TGT_SWI: cf_sel = SWI_OPCODE; // [R6]
      crm_pkg::TGT_NONE: cf_sel = UNMAPPED_DATA;
    endcase
  end

  always_comb begin
    unique case (dt_tgt)
      crm_pkg::TGT_RAM: dt_sel = dt_ram_rdata;
      crm_pkg::TGT_ROM: dt_sel = dt_rom_rdata;
      crm_pkg::TGT_SWI: dt_sel = UNMAPPED_DATA;
      crm_pkg::TGT_NONE: dt_sel = UNMAPPED_DATA;
    endcase
  end

  // ----------------------------------------------------------------
  // registered read returns
  // ----------------------------------------------------------------
  logic [7:0] cf_rdata_d;
  logic [7:0] dt_rdata_d;

  assign cf_rdata_d = cf_valid ? cf_sel : cf_rdata_q;
  assign dt_rdata_d = dt_valid ? dt_sel : dt_rdata_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cf_rvalid_q <= 1'b0;
      cf_rdata_q <= 8'h00;
    end else begin
      cf_rvalid_q <= cf_valid;
      cf_rdata_q <= cf_rdata_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dt_rvalid_q <= 1'b0;
      dt_rdata_q <= 8'h00;
    end else begin
      dt_rvalid_q <= dt_valid;
      dt_rdata_q <= dt_rdata_d;
    end
  end

endmodule : crm_top

/* crm_top_monitor.sv */
// checker: concurrent checks on the remap block ports
module crm_top_monitor #(
  parameter logic [7:0] SWI_OPCODE = 8'hff
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic cf_valid,
  input wire logic cf_vector,
  input wire logic [15:0] cf_addr,
  input crm_pkg::crm_mem_s cf_mem,
  input wire logic cf_rvalid_q,
  input wire logic [7:0] cf_rdata_q,
  input wire logic dt_valid,
  input wire logic [15:0] dt_addr,
  input crm_pkg::crm_mem_s dt_mem,
  input crm_pkg::crm_map_s map_committed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire rd_acc = psel && penable && !pwrite;
  wire unlock = psel && penable && pwrite && pstrb[0] && paddr == crm_pkg::COMMIT_ADDR && pwdata[7:0] == 8'hd4;
  wire win = cf_addr >= 16'h0040 && cf_addr <= 16'h083f;
  wire vtab = cf_vector && ((cf_addr >= 16'hffa0 && cf_addr <= 16'hffbf) || (cf_addr >= 16'hffcc && cf_addr <= 16'hfffd));
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_hold; !unlock |=> $stable(map_committed); endproperty
  a_hold: assert property (p_hold) else $error("map changed without unlock");
  property p_ctrl; rd_acc && paddr == crm_pkg::CTRL_ADDR |-> prdata[31:3] == 29'h0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control upper bits not zero");
  property p_stat; rd_acc && paddr == crm_pkg::COMMIT_ADDR |-> prdata == {29'h0, map_committed, 1'b0}; endproperty
  a_stat: assert property (p_stat) else $error("state readback wrong");
  property p_win; cf_valid && win |-> cf_mem.ram_sel == map_committed.ram && !cf_mem.rom_sel; endproperty
  a_win: assert property (p_win) else $error("code window select wrong");
  property p_swi; cf_valid && win && !map_committed.ram |=> cf_rvalid_q && cf_rdata_q == SWI_OPCODE; endproperty
  a_swi: assert property (p_swi) else $error("window fetch not swi");
  property p_rel; cf_valid && vtab && map_committed.vec |-> cf_mem.addr == (cf_addr & 16'h01ff); endproperty
  a_rel: assert property (p_rel) else $error("vector not relocated");
  property p_home; cf_valid && vtab && !map_committed.vec |-> cf_mem.addr == cf_addr && cf_mem.rom_sel; endproperty
  a_home: assert property (p_home) else $error("vector moved while clear");
  property p_rstv; cf_valid && cf_vector && cf_addr >= 16'hfffe |-> cf_mem.addr == cf_addr && cf_mem.rom_sel; endproperty
  a_rstv: assert property (p_rstv) else $error("reset vector moved");
  property p_data; dt_valid && dt_addr >= 16'h0040 && dt_addr <= 16'h083f |-> dt_mem.ram_sel; endproperty
  a_data: assert property (p_data) else $error("data ram not selected");
endmodule : crm_top_monitor

bind crm_top crm_top_monitor #(.SWI_OPCODE(SWI_OPCODE)) u_mon (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .cf_valid(cf_valid), .cf_vector(cf_vector), .cf_addr(cf_addr), .cf_mem(cf_mem), .cf_rvalid_q(cf_rvalid_q),
  .cf_rdata_q(cf_rdata_q), .dt_valid(dt_valid), .dt_addr(dt_addr), .dt_mem(dt_mem), .map_committed(map_committed));

/* crm_top_tb.sv */
// testbench: register, commit and fetch decode checks for the remap block
module crm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic cf_valid, cf_vector, cf_rvalid_q, dt_valid, dt_rvalid_q;
  logic [15:0] paddr, cf_addr, dt_addr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0] pstrb;
  logic [7:0] cf_ram_rdata, cf_rom_rdata, cf_rdata_q, dt_ram_rdata, dt_rom_rdata, dt_rdata_q;
  crm_pkg::crm_mem_s cf_mem, dt_mem;
  crm_pkg::crm_map_s map_committed;
  logic [2:0] pend;
  logic [1:0] comm;
  logic [25:0] ex;
  int error_cnt = 0;
  int tests_run = 0;
  logic [15:0] corner [16] = '{16'h0040, 16'h083f, 16'h003f, 16'h0840, 16'h01a0, 16'h01bf, 16'h01cc, 16'h01fd,
    16'hffa0, 16'hffbf, 16'hffcc, 16'hfffd, 16'hfffe, 16'hffff, 16'hc000, 16'hbfff};
  crm_top uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cf_valid(cf_valid),
    .cf_vector(cf_vector), .cf_addr(cf_addr), .cf_mem(cf_mem), .cf_ram_rdata(cf_ram_rdata),
    .cf_rom_rdata(cf_rom_rdata), .cf_rvalid_q(cf_rvalid_q), .cf_rdata_q(cf_rdata_q), .dt_valid(dt_valid),
    .dt_addr(dt_addr), .dt_mem(dt_mem), .dt_ram_rdata(dt_ram_rdata), .dt_rom_rdata(dt_rom_rdata),
    .dt_rvalid_q(dt_rvalid_q), .dt_rdata_q(dt_rdata_q), .map_committed(map_committed));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // returns {ram_sel, rom_sel, addr, byte} for a code fetch
  function automatic logic [25:0] expf(logic v, logic [15:0] a, logic [7:0] rb, logic [7:0] ob);
    logic [15:0] e;
    e = (v && comm[1] && ((a >= 16'hffa0 && a <= 16'hffbf) || (a >= 16'hffcc && a <= 16'hfffd))) ? a & 16'h01ff : a;
    if (e >= 16'hc000) return {2'b01, e, ob};
    if (e >= 16'h0040 && e <= 16'h083f) return comm[0] ? {2'b10, e, rb} : {2'b00, e, 8'hff};
    return {2'b00, e, 8'h00};
  endfunction : expf
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic fetch(input logic v, input logic [15:0] a);
    @(posedge mclk);
    cf_valid <= 1'b1;
    dt_valid <= 1'b1;
    cf_vector <= v;
    cf_addr <= a;
    dt_addr <= a;
    cf_ram_rdata <= seed[7:0];
    dt_ram_rdata <= seed[7:0];
    cf_rom_rdata <= seed[15:8];
    dt_rom_rdata <= seed[15:8];
    @(negedge mclk);
    ex = expf(v, a, seed[7:0], seed[15:8]);
    chk("cf_mem", {14'h0, ex[25:8]}, {14'h0, cf_mem});
    chk("dt_mem", {14'h0, a >= 16'h0040 && a <= 16'h083f, a >= 16'hc000, a}, {14'h0, dt_mem});
    chk("map", {30'h0, comm}, {30'h0, map_committed});
    @(posedge mclk);
    cf_valid <= 1'b0;
    dt_valid <= 1'b0;
    @(negedge mclk);
    chk("cf_rdata", {23'h0, 1'b1, ex[7:0]}, {23'h0, cf_rvalid_q, cf_rdata_q});
    ex[7:0] = (a >= 16'h0040 && a <= 16'h083f) ? seed[7:0] : (a >= 16'hc000 ? seed[15:8] : 8'h00);
    chk("dt_rdata", {23'h0, 1'b1, ex[7:0]}, {23'h0, dt_rvalid_q, dt_rdata_q});
  endtask : fetch
  task automatic final_report();
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b100, 49'h0, 4'hf};
    {cf_valid, cf_vector, cf_addr, dt_valid, dt_addr} = 35'h0;
    {cf_ram_rdata, cf_rom_rdata, dt_ram_rdata, dt_rom_rdata} = 32'h0;
    {seed, pend, comm} = {32'h9bc741c9, 5'h0};
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, crm_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    pstrb <= 4'he;
    apb(1'b1, crm_pkg::CTRL_ADDR, 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, crm_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl_strb", 32'h0, rd);
    apb(1'b0, crm_pkg::COMMIT_ADDR, 32'h0);
    chk("state_reset", 32'h0, rd);
    fetch(1'b0, 16'h0040);
    apb(1'b1, crm_pkg::CTRL_ADDR, 32'hff);
    pend = 3'h7;
    apb(1'b0, crm_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl_rd", 32'h7, rd);
    fetch(1'b1, 16'hffa0);
    apb(1'b1, crm_pkg::COMMIT_ADDR, 32'hd5);
    fetch(1'b0, 16'h083f);
    apb(1'b1, crm_pkg::COMMIT_ADDR, 32'hd4);
    comm = pend[2:1];
    apb(1'b0, crm_pkg::COMMIT_ADDR, 32'h0);
    chk("state", 32'h6, rd);
    apb(1'b0, 16'h0100, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    repeat (300) begin
      seed = lfsr(seed);
      if (seed[3:0] == 4'h0) begin
        pend = {seed[5] & seed[6], seed[6], seed[7]};
        apb(1'b1, crm_pkg::CTRL_ADDR, {29'h0, pend});
        apb(1'b1, crm_pkg::COMMIT_ADDR, seed[4] ? 32'hd4 : {24'h0, seed[15:8]});
        if (seed[4] || seed[15:8] == 8'hd4) comm = pend[2:1];
      end
      fetch(seed[20], seed[21] ? corner[seed[19:16]] : seed[31:16]);
    end
    final_report();
  end
endmodule : crm_top_tb
